// file: verilog/ias_defs.vh
// Shared constants for the two-wire register port of the converter.
// Assumes every file that includes it runs on the 200 MHz core clock.
`ifndef IAS_DEFS_VH
`define IAS_DEFS_VH

// Fixed upper three bits of the seven-bit slave address.
`define IAS_ADDR_PREFIX 3'h2

// Lower address bits contributed by one strap pin, per resolved level.
`define IAS_STRAP_BITS_HIGH 2'h0
`define IAS_STRAP_BITS_FLOAT 2'h2
`define IAS_STRAP_BITS_LOW 2'h3

// Resolved strap levels.
`define IAS_LVL_HIGH 2'h0
`define IAS_LVL_FLOAT 2'h1
`define IAS_LVL_LOW 2'h2

// Register addresses that the port itself treats specially.
`define IAS_CHAN_REG_ADDR 8'h01
`define IAS_CFG_REG_ADDR 8'h02

// Reset values of the pointer and the configuration register.
`define IAS_PTR_RESET 8'h00
`define IAS_CFG_RESET 16'h0000

// Core clock period and strap settling time, both in ns.
`define IAS_CLK_PERIOD_NS 5
`define IAS_STRAP_SETTLE_NS 1000

// Bit count of one byte on the wire, acknowledge excluded.
`define IAS_BYTE_BITS 4'h8

`endif

// file: verilog/ias_sync.v
// Three-flop input synchroniser with an agreement filter.
// Assumes the input is asynchronous to core_clk; the output is registered.
`timescale 1ns/1ps
`default_nettype none

module ias_sync
#(
   parameter RESET_VALUE = 1'b1
)
(
   input wire core_clk,
   input wire rstn,
   input wire pin_in,
   output reg level
);

   // First stage is read only by the second stage.
   reg stage1;
   // Second and third stages are compared against each other.
   reg stage2;
   reg stage3;

   ////////////////////////////////////////////////////////////////////////
   // A change is accepted once the second and third flops agree, so a
   // single-cycle glitch that reaches only one of them is dropped.
   always @(posedge core_clk)
   begin
      if (!rstn)
      begin
         stage1 <= RESET_VALUE;
         stage2 <= RESET_VALUE;
         stage3 <= RESET_VALUE;
         level <= RESET_VALUE;
      end
      else
      begin
         stage1 <= pin_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3)
         begin
            level <= stage3;
         end
      end
   end

endmodule

`default_nettype wire

// file: verilog/ias_strap.v
// Strap resolver: turns two three-level strap pins into the slave address.
// Assumes each pin is sensed twice by the pad, once under a weak pull-up and
// once under a weak pull-down, and that both senses arrive synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "ias_defs.vh"

module ias_strap
#(
   parameter SETTLE_CYCLES = `IAS_STRAP_SETTLE_NS / `IAS_CLK_PERIOD_NS
)
(
   input wire core_clk,
   input wire rstn,
   input wire low_up_sense,
   input wire low_dn_sense,
   input wire high_up_sense,
   input wire high_dn_sense,
   output reg [6:0] slave_addr,
   output reg addr_valid
);

   // Settling counter started at reset release.
   reg [15:0] settle_cnt;

   // Resolve one pin: high under both pulls, low under both, else floating.
   function [1:0] resolve;
      input up_sense;
      input dn_sense;
      begin
         if (up_sense && dn_sense)
            resolve = `IAS_LVL_HIGH;
         else if (!up_sense && !dn_sense)
            resolve = `IAS_LVL_LOW;
         else
            resolve = `IAS_LVL_FLOAT;
      end
   endfunction

   // Map a resolved level to the two address bits it contributes.
   function [1:0] level_bits;
      input [1:0] lvl;
      begin
         case (lvl)
            `IAS_LVL_HIGH: level_bits = `IAS_STRAP_BITS_HIGH;
            `IAS_LVL_LOW: level_bits = `IAS_STRAP_BITS_LOW;
            default: level_bits = `IAS_STRAP_BITS_FLOAT;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // The straps are caught once, after the settling time following reset,
   // because a floating pin needs the pulls to charge its stray load first.
   always @(posedge core_clk)
   begin
      if (!rstn)
      begin
         settle_cnt <= 16'h0000;
         slave_addr <= 7'h00;
         addr_valid <= 1'b0;
      end
      else if (!addr_valid)
      begin
         if (settle_cnt == SETTLE_CYCLES[15:0])
         begin
            slave_addr <= {`IAS_ADDR_PREFIX,
               level_bits(resolve(high_up_sense, high_dn_sense)),
               level_bits(resolve(low_up_sense, low_dn_sense))};
            addr_valid <= 1'b1;
         end
         else
         begin
            settle_cnt <= settle_cnt + 16'h0001;
         end
      end
   end

endmodule

`default_nettype wire

// file: verilog/ias_port.v
// Two-wire slave register port of the converter: address match, framing,
// pointer, 16-bit register writes and register reads.
// Assumes scl and sda arrive as raw pins; the master makes every clock pulse.
//
// Operation
// - Address upper bits are fixed 010.
// - Low nibble comes from the nine-entry strap map.
// - Each strap resolves to high, low or floating.
// - Both lines high and undriven means idle.
// - Start is sda falling while scl high.
// - Eight data bits then one acknowledge bit.
// - Data changes only while the clock is low.
// - Receiver acknowledges low; missing acknowledge abandons transaction.
// - First byte is address plus direction bit.
// - Direction zero writes, direction one reads.
// - One transaction is either write or read.
// - Repeated start begins a new transaction.
// - Stop is sda rising while scl high.
// - Registers other than channel take two bytes.
// - Write order: address, pointer, high, low byte.
// - Device acknowledges address and every written byte.
// - Further pointer and data groups may follow.
// - Pointer-only write selects register for later reads.
// - Pointer keeps its value across transactions.
// - Master nack on read ends device transmission.
`timescale 1ns/1ps
`default_nettype none
`include "ias_defs.vh"

module ias_port
#(
   parameter SETTLE_CYCLES = `IAS_STRAP_SETTLE_NS / `IAS_CLK_PERIOD_NS
)
(
   input wire core_clk,
   input wire rstn,
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire addr_strap_pin_low_up,
   input wire addr_strap_pin_low_dn,
   input wire addr_strap_pin_high_up,
   input wire addr_strap_pin_high_dn,
   output reg [7:0] reg_ptr,
   output reg reg_wr_en,
   output reg [7:0] reg_wr_addr,
   output reg [15:0] reg_wr_data,
   output reg reg_rd_strobe,
   input wire [15:0] reg_rd_data,
   output reg [15:0] cfg_reg,
   output reg bus_idle
);

   // Transaction states.
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_WRITE = 3'h2;
   localparam ST_READ = 3'h3;
   localparam ST_IGNORE = 3'h4;

   // Position of the next received byte inside a write group.
   localparam BY_PTR = 2'h0;
   localparam BY_MSB = 2'h1;
   localparam BY_LSB = 2'h2;
   localparam BY_CHAN = 2'h3;

   // Filtered bus lines.
   wire scl;
   wire sda;
   // Strap-derived address and its ready flag.
   wire [6:0] my_addr;
   wire addr_ready;

   // Previous line values for edge detection.
   reg scl_prev;
   reg sda_prev;
   // Current transaction state.
   reg [2:0] state;
   // Bits received or sent in the current byte.
   reg [3:0] bit_cnt;
   // Receive shift register.
   reg [7:0] shreg;
   // Position of the next write byte.
   reg [1:0] byte_pos;
   // Upper data byte held until the lower one completes the write.
   reg [7:0] msb_hold;
   // Word being sent, and which half of it is on the wire.
   reg [15:0] tx_word;
   reg tx_low_half;
   // Set during the acknowledge bit of the current byte.
   reg ack_phase;

   // Edge events on the filtered lines.
   wire scl_rise = scl && !scl_prev;
   wire scl_fall = !scl && scl_prev;
   wire start_cond = scl && scl_prev && sda_prev && !sda;
   wire stop_cond = scl && scl_prev && !sda_prev && sda;
   // Byte currently being transmitted.
   wire [7:0] tx_byte = tx_low_half ? tx_word[7:0] : tx_word[15:8];

   ////////////////////////////////////////////////////////////////////////
   // Input conditioning and strap capture.

   // Clock line synchroniser; the clock line is never driven here.
   ias_sync #(.RESET_VALUE(1'b1)) u_sync_scl
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in(scl_in),
      .level(scl)
   );

   // Data line synchroniser.
   ias_sync #(.RESET_VALUE(1'b1)) u_sync_sda
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in(sda_in),
      .level(sda)
   );

   // Strap sense lines, synchronised before resolution.
   wire low_up;
   wire low_dn;
   wire high_up;
   wire high_dn;

   ias_sync #(.RESET_VALUE(1'b0)) u_sync_lu
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in(addr_strap_pin_low_up),
      .level(low_up)
   );

   ias_sync #(.RESET_VALUE(1'b0)) u_sync_ld
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in(addr_strap_pin_low_dn),
      .level(low_dn)
   );

   ias_sync #(.RESET_VALUE(1'b0)) u_sync_hu
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in(addr_strap_pin_high_up),
      .level(high_up)
   );

   ias_sync #(.RESET_VALUE(1'b0)) u_sync_hd
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .pin_in(addr_strap_pin_high_dn),
      .level(high_dn)
   );

   // Resolver latches the address once after reset.
   ias_strap #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_strap
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .low_up_sense(low_up),
      .low_dn_sense(low_dn),
      .high_up_sense(high_up),
      .high_dn_sense(high_dn),
      .slave_addr(my_addr),
      .addr_valid(addr_ready)
   );

   ////////////////////////////////////////////////////////////////////////
   // Main sequencer. Sampling happens on scl rising, driving on scl
   // falling, so sda only ever moves while the clock is low.
   always @(posedge core_clk)
   begin
      if (!rstn)
      begin
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         byte_pos <= BY_PTR;
         msb_hold <= 8'h00;
         tx_word <= 16'h0000;
         tx_low_half <= 1'b0;
         ack_phase <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         reg_ptr <= `IAS_PTR_RESET;
         reg_wr_en <= 1'b0;
         reg_wr_addr <= 8'h00;
         reg_wr_data <= 16'h0000;
         reg_rd_strobe <= 1'b0;
         cfg_reg <= `IAS_CFG_RESET;
         bus_idle <= 1'b1;
      end
      else
      begin
         scl_prev <= scl;
         sda_prev <= sda;
         reg_wr_en <= 1'b0;
         reg_rd_strobe <= 1'b0;
         // Idle only when nothing is driven, both lines are high and no
         // transaction is open.
         bus_idle <= scl && sda && !sda_oe && (state == ST_IDLE);
         if (start_cond)
         begin
            // Start or repeated start abandons whatever was open; a half
            // finished write group is simply dropped.
            state <= addr_ready ? ST_ADDR : ST_IGNORE;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe <= 1'b0;
         end
         else if (stop_cond)
         begin
            // Pending upper byte is discarded without a write.
            state <= ST_IDLE;
            sda_oe <= 1'b0;
            ack_phase <= 1'b0;
         end
         else
         begin
            case (state)
               ST_ADDR, ST_WRITE:
               begin
                  if (scl_rise && !ack_phase)
                  begin
                     shreg <= {shreg[6:0], sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  else if (scl_fall && ack_phase)
                  begin
                     // End of the acknowledge bit: release the line.
                     ack_phase <= 1'b0;
                     sda_oe <= 1'b0;
                  end
                  else if (scl_fall && bit_cnt == `IAS_BYTE_BITS)
                  begin
                     bit_cnt <= 4'h0;
                     if (state == ST_ADDR)
                     begin
                        if (shreg[7:1] == my_addr)
                        begin
                           sda_oe <= 1'b1;
                           ack_phase <= 1'b1;
                           if (shreg[0])
                           begin
                              // Read: word of the held pointer is loaded now.
                              state <= ST_READ;
                              tx_word <= reg_rd_data;
                              tx_low_half <= 1'b0;
                              reg_rd_strobe <= 1'b1;
                           end
                           else
                           begin
                              state <= ST_WRITE;
                              byte_pos <= BY_PTR;
                           end
                        end
                        else
                        begin
                           // Not ours: stay off the line until next start.
                           state <= ST_IGNORE;
                        end
                     end
                     else
                     begin
                        // Every written byte is acknowledged.
                        sda_oe <= 1'b1;
                        ack_phase <= 1'b1;
                        case (byte_pos)
                           BY_PTR:
                           begin
                              // Pointer persists beyond this transaction.
                              reg_ptr <= shreg;
                              byte_pos <= (shreg == `IAS_CHAN_REG_ADDR) ?
                                 BY_CHAN : BY_MSB;
                           end
                           BY_MSB:
                           begin
                              msb_hold <= shreg;
                              byte_pos <= BY_LSB;
                           end
                           BY_LSB:
                           begin
                              // Both bytes in: commit, then expect a new
                              // pointer for a further group.
                              reg_wr_en <= 1'b1;
                              reg_wr_addr <= reg_ptr;
                              reg_wr_data <= {msb_hold, shreg};
                              if (reg_ptr == `IAS_CFG_REG_ADDR)
                              begin
                                 cfg_reg <= {msb_hold, shreg};
                              end
                              byte_pos <= BY_PTR;
                           end
                           default:
                           begin
                              // Channel register takes a single byte.
                              reg_wr_en <= 1'b1;
                              reg_wr_addr <= reg_ptr;
                              reg_wr_data <= {8'h00, shreg};
                              byte_pos <= BY_PTR;
                           end
                        endcase
                     end
                  end
               end
               ST_READ:
               begin
                  if (scl_fall && ack_phase && sda_oe)
                  begin
                     // End of our own address acknowledge: first data bit.
                     ack_phase <= 1'b0;
                     sda_oe <= !tx_byte[7];
                     bit_cnt <= 4'h1;
                  end
                  else if (scl_rise && ack_phase)
                  begin
                     // Master acknowledge sampled; a high level ends sending.
                     if (sda)
                     begin
                        state <= ST_IGNORE;
                        ack_phase <= 1'b0;
                     end
                  end
                  else if (scl_fall && ack_phase)
                  begin
                     // Acked: next byte of the word, or the word again.
                     ack_phase <= 1'b0;
                     bit_cnt <= 4'h1;
                     if (tx_low_half)
                     begin
                        tx_low_half <= 1'b0;
                        tx_word <= reg_rd_data;
                        reg_rd_strobe <= 1'b1;
                        sda_oe <= !reg_rd_data[15];
                     end
                     else
                     begin
                        tx_low_half <= 1'b1;
                        sda_oe <= !tx_word[7];
                     end
                  end
                  else if (scl_fall && bit_cnt == `IAS_BYTE_BITS)
                  begin
                     // Release for the master's acknowledge bit.
                     sda_oe <= 1'b0;
                     ack_phase <= 1'b1;
                     bit_cnt <= 4'h0;
                  end
                  else if (scl_fall)
                  begin
                     // Open drain: drive only for a zero bit.
                     sda_oe <= !tx_byte[3'h7 - bit_cnt[2:0]];
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               ST_IGNORE:
               begin
                  // Line stays released until a start or stop.
                  sda_oe <= 1'b0;
               end
               default:
               begin
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// file: bench/ias_port_checker.sv
// Concurrent checks on the two-wire register port, bound to ias_port.
// Assumes only the top module's ports; scl_in and sda_in are raw pins.
`timescale 1ns/1ps
`default_nettype none

module ias_port_checker
(
   input wire core_clk,
   input wire rstn,
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   input wire [7:0] reg_ptr,
   input wire reg_wr_en,
   input wire [7:0] reg_wr_addr,
   input wire [15:0] reg_wr_data,
   input wire reg_rd_strobe,
   input wire [15:0] cfg_reg,
   input wire bus_idle
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////
   // Open drain: the port may only ever pull the line low.
   sda_low_a: assert property (sda_out == 1'b0)
      else $error("sda_out driven high");
   // Drive changes land in the low phase, since the filter lags scl.
   oe_edge_a: assert property (($rose(sda_oe) || $fell(sda_oe)) |-> !scl_in)
      else $error("sda_oe changed with scl high");
   oe_hold_a: assert property ($rose(sda_oe) |=> sda_oe [*8])
      else $error("sda_oe dropped early");
   wr_ack_a: assert property (reg_wr_en |-> $rose(sda_oe) && reg_wr_addr == reg_ptr)
      else $error("write pulse off the acknowledge");
   wr_pulse_a: assert property (reg_wr_en |=> !reg_wr_en)
      else $error("write pulse too long");
   cfg_load_a: assert property (reg_wr_en && reg_wr_addr == 8'h02 |=>
      cfg_reg == $past(reg_wr_data)) else $error("cfg not loaded");
   // The copy and the write pulse update on the same edge, so both are seen together.
   cfg_keep_a: assert property ($changed(cfg_reg) && $past(rstn) |->
      reg_wr_en && reg_wr_addr == 8'h02) else $error("cfg changed");
   chan_byte_a: assert property (reg_wr_en && reg_wr_addr == 8'h01 |->
      reg_wr_data[15:8] == 8'h00) else $error("channel upper byte set");
   idle_free_a: assert property (bus_idle |-> !sda_oe)
      else $error("idle while driving");
   start_busy_a: assert property ($fell(sda_in) && scl_in |-> ##[1:10] !bus_idle)
      else $error("start not seen");
   stop_idle_a: assert property ($rose(sda_in) && scl_in |-> ##[1:12] bus_idle)
      else $error("stop not seen");
   ptr_hold_a: assert property ($changed(reg_ptr) && $past(rstn) |-> !bus_idle)
      else $error("pointer moved while idle");
   rd_pulse_a: assert property (reg_rd_strobe |=> !reg_rd_strobe)
      else $error("read strobe too long");
endmodule

bind ias_port ias_port_checker chk
(
   .core_clk(core_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .reg_wr_en(reg_wr_en),
   .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
   .reg_rd_strobe(reg_rd_strobe), .cfg_reg(cfg_reg), .bus_idle(bus_idle)
);
`default_nettype wire

// file: bench/ias_master_model.sv
// Behavioural bus master that faces the register port.
// Assumes a pulled-up sda wire; all changes fall on core_clk falling edges.
`timescale 1ns/1ps
`default_nettype none

module ias_master_model
(
   input wire logic core_clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // The clock stands high outside frames and the data line is released.
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // A quarter of the 80 ns serial clock period.
   task automatic quarter;
      repeat (4) @(negedge core_clk);
   endtask

   // One bit: data set while scl is low, sampled mid-high.
   task automatic clock_bit(input logic b, output logic r);
      sda_low = !b;
      quarter;
      scl = 1'b1;
      quarter;
      r = sda_line;
      quarter;
      scl = 1'b0;
      quarter;
   endtask

   // Start from idle, or repeated start from a low clock.
   task automatic start;
      sda_low = 1'b0;
      quarter;
      scl = 1'b1;
      quarter;
      sda_low = 1'b1;
      quarter;
      scl = 1'b0;
      quarter;
   endtask

   // Stop: clock released first, then data.
   task automatic stop;
      sda_low = 1'b1;
      quarter;
      scl = 1'b1;
      quarter;
      sda_low = 1'b0;
      repeat (6) quarter;
   endtask

   // Eight bits msb first, then the acknowledge slot with sda released.
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         clock_bit(d[i], r);
      clock_bit(1'b1, r);
      ack = !r;
   endtask

   // Receive a byte; a final byte is refused so the port stops sending.
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         clock_bit(1'b1, d[i]);
      clock_bit(last, r);
   endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for ias_port with a behavioural bus master.
// Assumes a short strap settle time; straps are changed only right before a reset.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   localparam logic [7:0] ADDR_W = 8'h54;
   localparam logic [7:0] ADDR_R = 8'h55;
   logic core_clk, rstn, scl, m_low, sda_line, sda_out, sda_oe;
   logic reg_wr_en, reg_rd_strobe, bus_idle;
   logic [1:0] lvl_h = 2'h1;
   logic [1:0] lvl_l = 2'h1;
   logic [7:0] reg_ptr, reg_wr_addr;
   logic [15:0] reg_wr_data, cfg_reg, rd_word;
   logic [23:0] wr_last;
   int wr_cnt = 0;
   int rd_cnt = 0;
   int err_total = 0;
   int num_checks = 0;
   int cyc = 0;

   // Open-drain wire with pull-up; the register side mirrors the pointer.
   assign sda_line = !(m_low || (sda_oe && !sda_out));
   assign rd_word = {reg_ptr, ~reg_ptr};

   ias_master_model m (.core_clk(core_clk), .sda_line(sda_line), .scl(scl), .sda_low(m_low));

   // Strap levels: 0 high, 1 floating, 2 low, sensed under pull-up and pull-down.
   ias_port #(.SETTLE_CYCLES(8)) dut
   (
      .core_clk(core_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_strap_pin_low_up(lvl_l != 2'h2), .addr_strap_pin_low_dn(lvl_l == 2'h0),
      .addr_strap_pin_high_up(lvl_h != 2'h2), .addr_strap_pin_high_dn(lvl_h == 2'h0),
      .reg_ptr(reg_ptr), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .reg_rd_strobe(reg_rd_strobe), .reg_rd_data(rd_word),
      .cfg_reg(cfg_reg), .bus_idle(bus_idle)
   );

   ////////////////////////////////////////////////////////////////
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Count write and read pulses, keep the last write; also bound the run.
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         err_total++;
         finish_test;
      end
      if (reg_wr_en)
      begin
         wr_cnt <= wr_cnt + 1;
         wr_last <= {reg_wr_addr, reg_wr_data};
      end
      if (reg_rd_strobe)
         rd_cnt <= rd_cnt + 1;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Reset long enough for the straps to settle afterwards.
   task automatic do_reset;
      @(negedge core_clk);
      rstn = 1'b0;
      repeat (10) @(negedge core_clk);
      rstn = 1'b1;
      repeat (30) @(negedge core_clk);
   endtask

   function automatic logic [1:0] nib(input logic [1:0] l);
      return (l == 2'h0) ? 2'h0 : (l == 2'h1) ? 2'h2 : 2'h3;
   endfunction

   task automatic put_ack(input logic [7:0] d);
      logic a;
      m.send_byte(d, a);
      check(a, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////
   // All nine strap pairs; a wrong prefix is ignored, the right one acked.
   task automatic t_addr_map;
      logic a;
      logic [6:0] sa;
      for (int h = 0; h < 3; h++)
         for (int l = 0; l < 3; l++)
         begin
            lvl_h = h[1:0];
            lvl_l = l[1:0];
            do_reset;
            sa = {3'h2, nib(lvl_h), nib(lvl_l)};
            m.start;
            m.send_byte({sa ^ 7'h40, 1'b0}, a);
            check(a, 1'b0);
            m.send_byte(8'h00, a);
            check(a, 1'b0);
            m.start;
            m.send_byte({sa, 1'b0}, a);
            check(a, 1'b1);
            m.stop;
         end
      lvl_h = 2'h1;
      lvl_l = 2'h1;
      do_reset;
   endtask

   task automatic t_write16;
      int n;
      n = wr_cnt;
      m.start;
      check(bus_idle, 1'b0);
      put_ack(ADDR_W);
      put_ack(8'h05);
      check(reg_ptr, 8'h05);
      put_ack(8'h12);
      check(wr_cnt, n);
      put_ack(8'h34);
      m.stop;
      check(wr_cnt, n + 1);
      check(wr_last, 24'h051234);
      check(bus_idle, 1'b1);
   endtask

   // Config, channel and another register in one transaction.
   task automatic t_multi;
      int n;
      n = wr_cnt;
      m.start;
      put_ack(ADDR_W);
      put_ack(8'h02);
      put_ack(8'hA5);
      put_ack(8'h5A);
      check(cfg_reg, 16'hA55A);
      put_ack(8'h01);
      put_ack(8'h0C);
      check(wr_last, 24'h01000C);
      put_ack(8'h07);
      put_ack(8'h0F);
      put_ack(8'h0E);
      m.stop;
      check(wr_last, 24'h070F0E);
      check(wr_cnt, n + 3);
   endtask

   // A stop after the upper byte leaves the register alone.
   task automatic t_partial;
      int n;
      n = wr_cnt;
      m.start;
      put_ack(ADDR_W);
      put_ack(8'h02);
      put_ack(8'h11);
      m.stop;
      check(cfg_reg, 16'hA55A);
      check(wr_cnt, n);
   endtask

   task automatic rd_pair(input logic last);
      logic [7:0] hi, lo;
      m.get_byte(1'b0, hi);
      m.get_byte(last, lo);
      check({hi, lo}, 16'h04FB);
   endtask

   // Pointer write, repeated start into a read, then a read with no pointer.
   // A word is fetched at the address acknowledge and after each acked lower byte.
   task automatic t_read;
      int n, r;
      n = wr_cnt;
      r = rd_cnt;
      m.start;
      put_ack(ADDR_W);
      put_ack(8'h04);
      m.start;
      put_ack(ADDR_R);
      rd_pair(1'b0);
      rd_pair(1'b1);
      m.stop;
      check(bus_idle, 1'b1);
      check(wr_cnt, n);
      check(rd_cnt, r + 2);
      m.start;
      put_ack(ADDR_R);
      rd_pair(1'b1);
      m.stop;
      check(reg_ptr, 8'h04);
      check(rd_cnt, r + 3);
   endtask

   initial
   begin
      rstn = 1'b0;
      do_reset;
      t_addr_map;
      t_write16;
      t_multi;
      t_partial;
      t_read;
      finish_test;
   end
endmodule
`default_nettype wire
